//--- core/swm_pkg.sv
// constants for the single-wire bus master
package swm_pkg;
    localparam int unsigned CLK_MHZ            = 250;
    localparam int unsigned RESET_LOW_TIME_US  = 480;
    localparam int unsigned RESET_HIGH_TIME_US = 480;
    localparam int unsigned PRESENCE_SAMPLE_US = 70;
    localparam int unsigned SLOT_TIME_US       = 70;
    localparam int unsigned WRITE_ONE_LOW_US   = 6;
    localparam int unsigned READ_SAMPLE_US     = 12;
    localparam int unsigned RECOVERY_US        = 5;
    localparam int unsigned PROG_PULSE_US      = 480;
    localparam int unsigned RESET_LOW_CYC      = RESET_LOW_TIME_US * CLK_MHZ;
    localparam int unsigned RESET_HIGH_CYC     = RESET_HIGH_TIME_US * CLK_MHZ;
    localparam int unsigned PRESENCE_SAMPLE_CYC = PRESENCE_SAMPLE_US * CLK_MHZ;
    localparam int unsigned SLOT_CYC           = SLOT_TIME_US * CLK_MHZ;
    localparam int unsigned WRITE_ONE_LOW_CYC  = WRITE_ONE_LOW_US * CLK_MHZ;
    localparam int unsigned READ_SAMPLE_CYC    = READ_SAMPLE_US * CLK_MHZ;
    localparam int unsigned RECOVERY_CYC       = RECOVERY_US * CLK_MHZ;
    localparam int unsigned PROG_PULSE_CYC     = PROG_PULSE_US * CLK_MHZ;
    localparam int unsigned CNT_W              = 20;
    localparam int unsigned FIFO_DEPTH         = 8;
    localparam int unsigned FIFO_WIDTH         = 8;
    localparam logic [7:0]  CRC_POLY_REFL      = 8'h8C;
    localparam logic [7:0]  CRC_RESET          = 8'h00;
    localparam logic [7:0]  CMD_READ_ID        = 8'h33;
    localparam logic [7:0]  CMD_SELECT_ID      = 8'h55;
    localparam logic [7:0]  CMD_BROADCAST      = 8'hCC;
    localparam logic [7:0]  CMD_ENUMERATE      = 8'hF0;
    // host operations
    typedef enum logic [2:0]
    {
        SWM_OP_RESET   = 3'd0,
        SWM_OP_WRITE   = 3'd1,
        SWM_OP_READ    = 3'd2,
        SWM_OP_TRIPLET = 3'd3,
        SWM_OP_PROGRAM = 3'd4
    } swm_op_e;
endpackage

//--- core/swm_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module swm_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 8
)
(
    input  wire logic             clk_i,
    input  wire logic             sys_rst_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    output logic [WIDTH-1:0]      out_data_o,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      count_reg;
    logic             push;
    logic             pop;

    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;
    assign in_ready_o  = (count_reg != (AW+1)'(DEPTH));
    assign out_valid_o = (count_reg != '0);
    assign out_data_o  = mem_reg[rd_ptr_reg];

    always_ff @(posedge clk_i)
    begin
        if (push)
        begin
            mem_reg[wr_ptr_reg] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + AW'(1);
            end
            if (pop)
            begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + AW'(1);
            end
            count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

//--- core/swm_master.sv
// single-wire bus master: reset, slots, triplets, program pulse, crc
`timescale 1ns/1ps
module swm_master
(
    input  wire logic       clk_i,
    input  wire logic       sys_rst_i,
    // command port
    input  wire logic [2:0] op_i,
    input  wire logic [7:0] op_data_i,
    input  wire logic       op_valid_i,
    output logic            op_ready_o,
    // result port through the fifo, then direct status outputs
    output logic [7:0]      rd_data_o,
    output logic            rd_valid_o,
    input  wire logic       rd_ready_i,
    output logic            presence_o,
    output logic [7:0]      crc_o,
    output logic            busy_o,
    output logic            prog_en_o,
    // open-drain line
    input  wire logic       line_i,
    output logic            line_o,
    output logic            line_oe_n_o
);
    // ------------------------------------------------------------
    // states
    // ------------------------------------------------------------
    typedef enum logic [2:0]
    {
        SWM_IDLE  = 3'b000,
        SWM_LOW   = 3'b001,
        SWM_HIGH  = 3'b011,
        SWM_REC   = 3'b010,
        SWM_PUSH  = 3'b110
    } swm_state_e;

    swm_state_e       state_reg;
    swm_pkg::swm_op_e op_reg;
    logic [19:0]      cnt_reg;
    logic [19:0]      low_len;
    logic [19:0]      samp_at;
    logic [19:0]      end_at;
    logic [7:0]       shift_reg;
    logic [3:0]       bits_reg;
    logic [1:0]       trip_reg;
    logic [1:0]       trip_rd_reg;
    logic             dir_reg;
    logic             sync1_reg;
    logic             sync2_reg;
    logic             line_drive_reg;
    logic             presence_reg;
    logic [7:0]       crc_reg;
    logic             busy_reg;
    logic             prog_reg;
    logic             op_ready_reg;
    logic             bit_out;
    logic             fifo_ready;
    logic             fifo_valid;
    logic [7:0]       fifo_data;
    logic             slot_done;

    // ------------------------------------------------------------
    // crc step, reflected form of x8+x5+x4+1
    // ------------------------------------------------------------
    function automatic logic [7:0] crc_step(input logic [7:0] c, input logic b);
        logic fb;
        fb = c[0] ^ b;
        crc_step = (c >> 1) ^ (fb ? swm_pkg::CRC_POLY_REFL : 8'h00);
    endfunction

    // ------------------------------------------------------------
    // line input synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            sync1_reg <= 1'b1;
            sync2_reg <= 1'b1;
        end
        else
        begin
            sync1_reg <= line_i;
            sync2_reg <= sync1_reg;
        end
    end

    // ------------------------------------------------------------
    // slot timing per operation
    // ------------------------------------------------------------
    // triplet step 2 writes, steps 0/1 read; lsb of shift is next bit
    assign bit_out = (op_reg == swm_pkg::SWM_OP_TRIPLET) ? dir_reg : shift_reg[0];

    always_comb
    begin
        low_len = 20'(swm_pkg::WRITE_ONE_LOW_CYC);
        samp_at = 20'(swm_pkg::READ_SAMPLE_CYC);
        end_at  = 20'(swm_pkg::SLOT_CYC);
        unique case (op_reg)
            swm_pkg::SWM_OP_RESET:
            begin
                // counter runs on from the falling edge, so the high window follows the low one
                low_len = 20'(swm_pkg::RESET_LOW_CYC);
                samp_at = 20'(swm_pkg::RESET_LOW_CYC + swm_pkg::PRESENCE_SAMPLE_CYC);
                end_at  = 20'(swm_pkg::RESET_LOW_CYC + swm_pkg::RESET_HIGH_CYC);
            end
            swm_pkg::SWM_OP_PROGRAM:
            begin
                low_len = 20'd1;
                end_at  = 20'(swm_pkg::PROG_PULSE_CYC);
            end
            swm_pkg::SWM_OP_WRITE:
            begin
                low_len = bit_out ? 20'(swm_pkg::WRITE_ONE_LOW_CYC) : 20'(swm_pkg::SLOT_CYC);
            end
            swm_pkg::SWM_OP_TRIPLET:
            begin
                if (trip_reg == 2'd2 && !dir_reg)
                begin
                    low_len = 20'(swm_pkg::SLOT_CYC);
                end
            end
            default:
            begin
                low_len = 20'(swm_pkg::WRITE_ONE_LOW_CYC);
            end
        endcase
    end

    assign slot_done = (state_reg == SWM_REC) && (cnt_reg == 20'(swm_pkg::RECOVERY_CYC));

    // ------------------------------------------------------------
    // main sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            state_reg      <= SWM_IDLE;
            op_reg         <= swm_pkg::SWM_OP_RESET;
            cnt_reg        <= '0;
            shift_reg      <= '0;
            bits_reg       <= '0;
            trip_reg       <= '0;
            trip_rd_reg    <= '0;
            dir_reg        <= 1'b0;
            line_drive_reg <= 1'b0;
            presence_reg   <= 1'b0;
            busy_reg       <= 1'b0;
            prog_reg       <= 1'b0;
            op_ready_reg   <= 1'b1;
        end
        else
        begin
            unique case (state_reg)
                SWM_IDLE:
                begin
                    cnt_reg <= '0;
                    if (op_valid_i)
                    begin
                        op_reg    <= swm_pkg::swm_op_e'(op_i);
                        shift_reg <= op_data_i;
                        dir_reg   <= op_data_i[0];
                        bits_reg  <= (op_i == 3'(swm_pkg::SWM_OP_WRITE) || op_i == 3'(swm_pkg::SWM_OP_READ))
                                     ? 4'd8 : 4'd1;
                        trip_reg  <= '0;
                        busy_reg  <= 1'b1;
                        op_ready_reg <= 1'b0;
                        if (op_i == 3'(swm_pkg::SWM_OP_PROGRAM))
                        begin
                            prog_reg <= 1'b1;
                        end
                        else
                        begin
                            line_drive_reg <= 1'b1;
                        end
                        state_reg <= SWM_LOW;
                    end
                end
                SWM_LOW:
                begin
                    cnt_reg <= cnt_reg + 20'd1;
                    if (cnt_reg + 20'd1 >= low_len)
                    begin
                        line_drive_reg <= 1'b0;
                        state_reg      <= SWM_HIGH;
                    end
                end
                SWM_HIGH:
                begin
                    cnt_reg <= cnt_reg + 20'd1;
                    if (cnt_reg == samp_at)
                    begin
                        if (op_reg == swm_pkg::SWM_OP_RESET)
                        begin
                            presence_reg <= !sync2_reg;
                        end
                        else if (op_reg == swm_pkg::SWM_OP_READ)
                        begin
                            shift_reg <= {sync2_reg, shift_reg[7:1]};
                        end
                        else if (op_reg == swm_pkg::SWM_OP_TRIPLET && trip_reg != 2'd2)
                        begin
                            trip_rd_reg[trip_reg[0]] <= sync2_reg;
                        end
                    end
                    if (cnt_reg + 20'd1 >= end_at)
                    begin
                        prog_reg  <= 1'b0;
                        cnt_reg   <= '0;
                        state_reg <= SWM_REC;
                    end
                end
                SWM_REC:
                begin
                    cnt_reg <= cnt_reg + 20'd1;
                    if (slot_done)
                    begin
                        cnt_reg <= '0;
                        if (op_reg == swm_pkg::SWM_OP_WRITE)
                        begin
                            shift_reg <= {1'b0, shift_reg[7:1]};
                        end
                        if (op_reg == swm_pkg::SWM_OP_TRIPLET && trip_reg == 2'd1)
                        begin
                            // both read bits known: resolve the written direction
                            if (trip_rd_reg[0] != trip_rd_reg[1])
                            begin
                                dir_reg <= trip_rd_reg[0];
                            end
                        end
                        if (op_reg == swm_pkg::SWM_OP_TRIPLET && trip_reg != 2'd2)
                        begin
                            trip_reg       <= trip_reg + 2'd1;
                            line_drive_reg <= 1'b1;
                            state_reg      <= SWM_LOW;
                        end
                        else if (bits_reg > 4'd1)
                        begin
                            bits_reg       <= bits_reg - 4'd1;
                            line_drive_reg <= 1'b1;
                            state_reg      <= SWM_LOW;
                        end
                        else
                        begin
                            state_reg <= SWM_PUSH;
                        end
                    end
                end
                SWM_PUSH:
                begin
                    // stall here until the fifo accepts the result
                    if (fifo_ready)
                    begin
                        busy_reg  <= 1'b0;
                        op_ready_reg <= 1'b1;
                        state_reg <= SWM_IDLE;
                    end
                end
                default:
                begin
                    op_ready_reg <= 1'b1;
                    state_reg <= SWM_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // running check over bytes on the wire
    // ------------------------------------------------------------
    // master only computes; comparing and deciding is software's job
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            crc_reg <= swm_pkg::CRC_RESET;
        end
        else if (state_reg == SWM_IDLE && op_valid_i && op_i == 3'(swm_pkg::SWM_OP_RESET))
        begin
            crc_reg <= swm_pkg::CRC_RESET;
        end
        else if (slot_done && op_reg == swm_pkg::SWM_OP_WRITE)
        begin
            crc_reg <= crc_step(crc_reg, shift_reg[0]);
        end
        else if (state_reg == SWM_HIGH && cnt_reg == samp_at && op_reg == swm_pkg::SWM_OP_READ)
        begin
            crc_reg <= crc_step(crc_reg, sync2_reg);
        end
        else if (slot_done && op_reg == swm_pkg::SWM_OP_TRIPLET && trip_reg == 2'd2)
        begin
            crc_reg <= crc_step(crc_reg, dir_reg);
        end
    end

    assign fifo_data = (op_reg == swm_pkg::SWM_OP_TRIPLET) ? {5'd0, dir_reg, trip_rd_reg}
                     : (op_reg == swm_pkg::SWM_OP_RESET)   ? {7'd0, presence_reg}
                     : shift_reg;
    assign fifo_valid = (state_reg == SWM_PUSH);

    swm_fifo #(
        .WIDTH (swm_pkg::FIFO_WIDTH),
        .DEPTH (swm_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (clk_i),
        .sys_rst_i   (sys_rst_i),
        .in_data_i   (fifo_data),
        .in_valid_i  (fifo_valid),
        .in_ready_o  (fifo_ready),
        .out_data_o  (rd_data_o),
        .out_valid_o (rd_valid_o),
        .out_ready_i (rd_ready_i)
    );

    // ------------------------------------------------------------
    // registered outputs; line_o is tied low
    // ------------------------------------------------------------
    assign op_ready_o  = op_ready_reg;
    assign line_o      = 1'b0;
    assign line_oe_n_o = !line_drive_reg;
    assign presence_o  = presence_reg;
    assign crc_o       = crc_reg;
    assign busy_o      = busy_reg;
    assign prog_en_o   = prog_reg;
endmodule

//--- tb/swm_master_chk.sv
// assertions on the ports of the single-wire bus master
`timescale 1ns/1ps
module swm_master_chk
(
    input wire logic       clk_i,
    input wire logic       sys_rst_i,
    input wire logic [2:0] op_i,
    input wire logic       op_valid_i,
    input wire logic       op_ready_o,
    input wire logic       busy_o,
    input wire logic       prog_en_o,
    input wire logic       line_o,
    input wire logic       line_oe_n_o
);
    localparam int US = 250;
    int low_cnt;
    int high_cnt;
    int prog_cnt;
    // ----------------------------------------
    // run lengths of pulled and released line
    // ----------------------------------------
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            low_cnt  <= 0;
            high_cnt <= 1000;  // start as long idle, first slot is no short recovery
        end
        else if (!line_oe_n_o)
        begin
            low_cnt  <= low_cnt + 1;
            high_cnt <= 0;
        end
        else
        begin
            low_cnt  <= 0;
            high_cnt <= (high_cnt < 1000) ? high_cnt + 1 : high_cnt;
        end
    end
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            prog_cnt <= 0;
        else if (prog_en_o)
            prog_cnt <= prog_cnt + 1;
        else
            prog_cnt <= 0;
    end
    // ----------------------------------------
    // properties
    // ----------------------------------------
    line_low_only_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) line_o == 1'b0)
        else $error("line output drives high");
    accept_busy_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        op_valid_i && op_ready_o |=> busy_o && !op_ready_o)
        else $error("accepted request did not make the block busy");
    slot_start_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        op_valid_i && op_ready_o && op_i != 3'd4 |-> ##[1:2] !line_oe_n_o)
        else $error("operation did not start with a low line");
    prog_release_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        prog_en_o |-> line_oe_n_o && busy_o)
        else $error("line pulled or block idle during program pulse");
    prog_width_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        $fell(prog_en_o) |-> prog_cnt == swm_pkg::PROG_PULSE_CYC)
        else $error("program pulse width wrong");
    low_time_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        $rose(line_oe_n_o) |-> low_cnt < 15 * US || (low_cnt >= 60 * US && low_cnt < 120 * US)
            || (low_cnt >= 480 * US && low_cnt < 960 * US))
        else $error("low phase outside every legal window");
    recovery_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        $fell(line_oe_n_o) |-> high_cnt >= US)
        else $error("recovery between slots too short");
    idle_release_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        $fell(busy_o) |-> line_oe_n_o)
        else $error("line left low after operation");
endmodule
bind swm_master swm_master_chk u_swm_master_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .op_i(op_i),
    .op_valid_i(op_valid_i), .op_ready_o(op_ready_o), .busy_o(busy_o), .prog_en_o(prog_en_o),
    .line_o(line_o), .line_oe_n_o(line_oe_n_o));

//--- tb/swm_slave_model.sv
// behavioural model of the single-wire slave device
`timescale 1ns/1ps
module swm_slave_model #(
    parameter logic [7:0]  FAMILY = 8'h5A,             // arbitrary value
    parameter logic [47:0] SERIAL = 48'h1234_5678_9ABC // arbitrary value
)
(
    input  wire logic line_i,
    output logic      pull_o
);
    logic [63:0] rom;
    logic [7:0]  cmd;
    logic [7:0]  c;
    int          nbit;
    int          phase;
    int          mode;  // 0 command, 1 identity read, 2 enumerate, 3 idle until reset, 4 select
    bit          in_pres;
    realtime     t_fall;
    initial
    begin
        c = 8'h00;
        for (int i = 0; i < 56; i++)
            c = (c >> 1) ^ ((c[0] ^ (i < 8 ? FAMILY[i] : SERIAL[i-8])) ? swm_pkg::CRC_POLY_REFL : 8'h00);
        rom = {c, SERIAL, FAMILY};
        pull_o = 1'b0;
        mode = 3;
        in_pres = 0;
        t_fall = 0;
    end
    // ----------------------------------------
    // reset detect and presence
    // ----------------------------------------
    always @(posedge line_i)
    begin
        if ($realtime - t_fall >= 480_000.0)
        begin
            in_pres = 1;
            mode = 0;
            nbit = 0;
            phase = 0;
            #30_000 pull_o = 1'b1;
            #120_000 pull_o = 1'b0;
            in_pres = 0;
        end
    end
    // ----------------------------------------
    // slots, timed from the master's falling edge
    // ----------------------------------------
    always @(negedge line_i)
    begin
        t_fall = $realtime;
        if (!in_pres && mode != 3)
        begin
            if (mode == 1 || (mode == 2 && phase < 2))
            begin
                if (rom[nbit] == (phase == 1)) // zero to send: hold low, else leave line alone
                begin
                    pull_o = 1'b1;
                    #15_000 pull_o = 1'b0;
                end
            end
            else
            begin
                #30_000;
                if (mode == 0)
                    cmd[nbit] = line_i;
                else if (line_i !== rom[nbit])
                    mode = 3;
            end
            if (mode == 2)
                phase = phase + 1;
            if (mode != 2 || phase == 3)
            begin
                phase = 0;
                nbit = nbit + 1;
            end
            if (mode == 0 && nbit == 8)
            begin
                nbit = 0;
                mode = (cmd == swm_pkg::CMD_READ_ID) ? 1 : (cmd == swm_pkg::CMD_ENUMERATE) ? 2 : 3;
                if (cmd == swm_pkg::CMD_SELECT_ID)
                    mode = 4;
            end
            if (nbit == 64)
                mode = 3;
        end
    end
endmodule

//--- tb/tb_top.sv
// self-checking bench for the single-wire bus master
`timescale 1ns/1ps
module tb_top;
    localparam logic [7:0]  FAM = 8'h5A;             // arbitrary value
    localparam logic [47:0] SER = 48'h1234_5678_9ABC; // arbitrary value
    logic       clk_i = 1'b0;
    logic       sys_rst_i = 1'b1;
    logic [2:0] op_i = 3'h0;
    logic [7:0] op_data_i = 8'h00;
    logic       op_valid_i = 1'b0;
    logic       rd_ready_i = 1'b0;
    logic [7:0] rd_data_o;
    logic       rd_valid_o;
    logic       op_ready_o;
    logic       presence_o;
    logic [7:0] crc_o;
    logic       busy_o;
    logic       prog_en_o;
    logic       line_o;
    logic       line_oe_n_o;
    logic       pull;
    wire        line_w = !((line_oe_n_o == 1'b0 && line_o == 1'b0) || pull); // pull-up
    int         failures = 0;
    int         n_checks = 0;
    logic [7:0] d;
    always #2 clk_i = ~clk_i;
    swm_master u_swm_master (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .op_i(op_i), .op_data_i(op_data_i),
        .op_valid_i(op_valid_i), .op_ready_o(op_ready_o), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
        .rd_ready_i(rd_ready_i), .presence_o(presence_o), .crc_o(crc_o), .busy_o(busy_o),
        .prog_en_o(prog_en_o), .line_i(line_w), .line_o(line_o), .line_oe_n_o(line_oe_n_o));
    swm_slave_model #(.FAMILY(FAM), .SERIAL(SER)) u_swm_slave_model (.line_i(line_w), .pull_o(pull));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic logic [7:0] crc_byte(input logic [7:0] c, input logic [7:0] b);
        for (int i = 0; i < 8; i++)
            c = (c >> 1) ^ ((c[0] ^ b[i]) ? 8'h8C : 8'h00);
        return c;
    endfunction
    task automatic run_op(input logic [2:0] op, input logic [7:0] data);
        int n;
        n = 0;
        @(negedge clk_i);
        op_i = op;
        op_data_i = data;
        op_valid_i = 1'b1;
        // ready seen settled at a falling edge: the next rising edge takes the request
        while (op_ready_o !== 1'b1 && n < 400000)
        begin
            n++;
            @(negedge clk_i);
        end
        check({31'h0, op_ready_o}, 32'h1);
        @(negedge clk_i);
        op_valid_i = 1'b0;
    endtask
    task automatic get_res(output logic [7:0] r);
        int n;
        n = 0;
        while (rd_valid_o !== 1'b1 && n < 400000)
        begin
            n++;
            @(negedge clk_i);
        end
        check({31'h0, rd_valid_o}, 32'h1);
        r = rd_data_o;
        rd_ready_i = 1'b1;
        @(negedge clk_i);
        rd_ready_i = 1'b0;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_presence();
        run_op(3'h0, 8'h00);
        get_res(d);
        check({31'h0, d[0]}, 32'h1);
        check({31'h0, presence_o}, 32'h1);
        check({24'h0, crc_o}, 32'h0);
    endtask
    task automatic t_read_id();
        run_op(3'h1, swm_pkg::CMD_READ_ID);
        get_res(d);
        run_op(3'h2, 8'h00);
        get_res(d);
        check({24'h0, d}, {24'h0, FAM});
        check({24'h0, crc_o}, {24'h0, crc_byte(crc_byte(8'h00, 8'h33), FAM)});
    endtask
    task automatic t_search_fill();
        logic [8:0] bits;
        bits = {SER[0], FAM};
        t_presence();
        run_op(3'h1, swm_pkg::CMD_ENUMERATE);
        get_res(d);
        for (int i = 0; i < 9; i++)
            run_op(3'h3, 8'h00);
        repeat (60000) @(negedge clk_i);
        check({31'h0, busy_o}, 32'h1); // fifo full, block stalls in push
        for (int i = 0; i < 9; i++)
        begin
            get_res(d);
            check({29'h0, d[2:0]}, {29'h0, bits[i], !bits[i], bits[i]});
        end
    endtask
    task automatic t_program();
        int n;
        n = 0;
        run_op(3'h4, 8'h00);
        while (prog_en_o !== 1'b1 && n < 10000)
        begin
            n++;
            @(negedge clk_i);
        end
        n = 0;
        while (prog_en_o === 1'b1 && n < 200000)
        begin
            n++;
            @(negedge clk_i);
        end
        check(n, swm_pkg::PROG_PULSE_CYC);
        get_res(d);
    endtask
    task automatic finish_test();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        #10_000_000;
        failures++;
        finish_test();
    end
    initial
    begin
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
        sys_rst_i = 1'b0;
        t_presence();
        t_read_id();
        t_search_fill();
        t_program();
        finish_test();
    end
endmodule
